// file: asel_top.v
// analog selector control: pin mode, channel routing and settle flag
// Summary of operation
// [R1] enable low: selector off, pin pulled to ground regardless of channel field
// [R2] enable high: selector on, five-bit channel field picks the routed signal
// [R3] enabled with code zero: selector off, pin left high impedance
// [R4] codes 1..3 route input supply /4, backup supply /3.5, coin cell /3
// [R5] codes 4..9 route bucks one..six, ratio 1.25 at 1.8 V else 1
// [R6] code 10 routes buck seven /2.86; codes 11..14 linear regulators /3.33
// [R7] codes 15..24 route temperature sensors undivided; codes 25..31 reserved
// [R8] buffered voltage driven on the pin only in system-on states
// [R9] sampler waits 50 us after enable or channel change before reading
// [R10] channel field kept independently of enable bit
`timescale 1ns/100ps
`default_nettype none
`include "asel_regs.vh"
module asel_top #(
    parameter SETTLE_CYCLES = (`ASEL_SETTLE_NS + `ASEL_CLK_NS - 1) / `ASEL_CLK_NS
) (
    input  wire                    clock,
    input  wire                    reset_n,
    input  wire                    analog_mux_enable,
    input  wire [`ASEL_SEL_W-1:0]  channel_select_field,
    input  wire                    select_write,
    input  wire                    system_on,
    input  wire [5:0]              buck_at_1p8,
    output reg  [`ASEL_PIN_W-1:0]  pin_mode,
    output reg                     pulldown_on,
    output reg                     buffer_oe,
    output reg  [24:0]             route_onehot,
    output reg  [`ASEL_DIV_W-1:0]  divider_code,
    output reg                     reserved_code,
    output wire                    settled
);
    // one-hot channel decode; index equals select code, bit 0 unused
    function [24:0] asel_decode;
        input [`ASEL_SEL_W-1:0] code;
        begin
            asel_decode = 25'h0;
            if (code != `ASEL_CODE_HIZ && code <= `ASEL_CODE_TEMP_LAST)
                asel_decode[code] = 1'b1;
        end
    endfunction

    reg [`ASEL_SEL_W-1:0] channel;
    reg                   enable_q;
    reg [`ASEL_PIN_W-1:0] next_pin_mode;
    reg [`ASEL_DIV_W-1:0] next_div;
    wire                  routing;
    wire [2:0]            buck_idx;

    // channel field kept apart from the enable bit
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            channel  <= `ASEL_SEL_RESET;
            enable_q <= 1'b0;
        end else begin
            enable_q <= analog_mux_enable;
            if (select_write) begin
                channel <= channel_select_field; // see [R10]
            end
        end
    end

    assign routing  = enable_q && channel != `ASEL_CODE_HIZ
                      && channel <= `ASEL_CODE_TEMP_LAST && system_on;
    assign buck_idx = channel[2:0] - 3'h4;

    always @* begin
        if (!enable_q) begin
            next_pin_mode = `ASEL_PIN_GROUND; // see [R1]
        end else if (channel == `ASEL_CODE_HIZ || !system_on
                     || channel > `ASEL_CODE_TEMP_LAST) begin
            next_pin_mode = `ASEL_PIN_HIZ; // see [R3] see [R8]
        end else begin
            next_pin_mode = `ASEL_PIN_DRIVE; // see [R2]
        end
    end

    always @* begin
        next_div = `ASEL_DIV_NONE;
        if (!enable_q) begin
            next_div = `ASEL_DIV_NONE;
        end else if (channel == `ASEL_CODE_VIN) begin
            next_div = `ASEL_DIV_4; // see [R4]
        end else if (channel == `ASEL_CODE_BACKUP) begin
            next_div = `ASEL_DIV_3P5; // see [R4]
        end else if (channel == `ASEL_CODE_COIN) begin
            next_div = `ASEL_DIV_3; // see [R4]
        end else if (channel >= `ASEL_CODE_BUCK1 && channel <= `ASEL_CODE_BUCK6) begin
            next_div = buck_at_1p8[buck_idx] ? `ASEL_DIV_1P25 : `ASEL_DIV_1; // see [R5]
        end else if (channel == `ASEL_CODE_BUCK7) begin
            next_div = `ASEL_DIV_2P86; // see [R6]
        end else if (channel >= `ASEL_CODE_LIN1 && channel <= `ASEL_CODE_LIN4) begin
            next_div = `ASEL_DIV_3P33; // see [R6]
        end else if (channel >= `ASEL_CODE_TEMP_DIE
                     && channel <= `ASEL_CODE_TEMP_LAST) begin
            next_div = `ASEL_DIV_1; // see [R7]
        end
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_mode      <= `ASEL_PIN_GROUND;
            pulldown_on   <= 1'b1;
            buffer_oe     <= 1'b0;
            route_onehot  <= 25'h0;
            divider_code  <= `ASEL_DIV_NONE;
            reserved_code <= 1'b0;
        end else begin
            pin_mode      <= next_pin_mode;
            pulldown_on   <= (next_pin_mode == `ASEL_PIN_GROUND); // see [R1]
            buffer_oe     <= (next_pin_mode == `ASEL_PIN_DRIVE); // see [R8]
            route_onehot  <= routing ? asel_decode(channel) : 25'h0; // see [R2]
            divider_code  <= routing ? next_div : `ASEL_DIV_NONE;
            reserved_code <= enable_q && channel > `ASEL_CODE_TEMP_LAST; // see [R7]
        end
    end

    // restart on enable rise or any channel change
    asel_settle #(
        .SETTLE_CYCLES (SETTLE_CYCLES),
        .CW            (14)
    ) u_settle (
        .clock   (clock),
        .reset_n (reset_n),
        .restart ((analog_mux_enable && !enable_q)
                  || (select_write && channel_select_field != channel)), // see [R9]
        .active  (routing),
        .settled (settled)
    );
endmodule // asel_top
`default_nettype wire

// file: asel_regs.vh
// constants for the analog selector control logic
`ifndef ASEL_REGS_VH
`define ASEL_REGS_VH
`define ASEL_SEL_W          5
`define ASEL_CODE_HIZ       5'h0_0
`define ASEL_CODE_VIN       5'h0_1
`define ASEL_CODE_BACKUP    5'h0_2
`define ASEL_CODE_COIN      5'h0_3
`define ASEL_CODE_BUCK1     5'h0_4
`define ASEL_CODE_BUCK6     5'h0_9
`define ASEL_CODE_BUCK7     5'h0_A
`define ASEL_CODE_LIN1      5'h0_B
`define ASEL_CODE_LIN4      5'h0_E
`define ASEL_CODE_TEMP_DIE  5'h0_F
`define ASEL_CODE_TEMP_LAST 5'h1_8
`define ASEL_SEL_RESET      5'h0_0
// divider ratio codes reported alongside the routed channel
`define ASEL_DIV_W          3
`define ASEL_DIV_NONE       3'h0
`define ASEL_DIV_1          3'h1
`define ASEL_DIV_1P25       3'h2
`define ASEL_DIV_2P86       3'h3
`define ASEL_DIV_3          3'h4
`define ASEL_DIV_3P33       3'h5
`define ASEL_DIV_3P5        3'h6
`define ASEL_DIV_4          3'h7
// pin modes
`define ASEL_PIN_W          2
`define ASEL_PIN_GROUND     2'h0
`define ASEL_PIN_HIZ        2'h1
`define ASEL_PIN_DRIVE      2'h2
// settling time in ns and cycles at 4 ns
`define ASEL_SETTLE_NS      50000
`define ASEL_CLK_NS         4
`endif

// file: asel_settle.v
// settling timer restarted on every enable or channel change
`timescale 1ns/100ps
`default_nettype none
module asel_settle #(
    parameter SETTLE_CYCLES = 12500,
    parameter CW            = 14
) (
    input  wire clock,
    input  wire reset_n,
    input  wire restart,
    input  wire active,
    output reg  settled
);
    reg [CW-1:0] count;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count   <= {CW{1'b0}};
            settled <= 1'b0;
        end else if (!active || restart) begin
            count   <= {CW{1'b0}};
            settled <= 1'b0;
        end else if (count < SETTLE_CYCLES[CW-1:0] - 1'b1) begin
            count   <= count + 1'b1;
        end else begin
            settled <= 1'b1;
        end
    end
endmodule // asel_settle
`default_nettype wire

// file: asel_sampler.sv
// converter model that samples the selector pin
`timescale 1ns/100ps
`default_nettype none
module asel_sampler (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       buffer_oe,
    input  wire logic       settled,
    output var  logic [7:0] reads
);
    // readings taken before settling would be stale, so none are taken then
    always @(posedge clock or negedge reset_n)
        if (!reset_n) reads <= 8'h00;
        else if (buffer_oe && settled && reads != 8'hff) reads <= reads + 8'h01;
endmodule // asel_sampler
`default_nettype wire

// file: asel_top_assertions.sv
// checker for the selector outputs
`timescale 1ns/100ps
`default_nettype none
`include "asel_regs.vh"
module asel_chk (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        analog_mux_enable,
    input wire logic [5:0]  buck_at_1p8,
    input wire logic        pulldown_on,
    input wire logic        buffer_oe,
    input wire logic        reserved_code,
    input wire logic        settled,
    input wire logic [1:0]  pin_mode,
    input wire logic [2:0]  divider_code,
    input wire logic [24:0] route_onehot
);
    logic [1:0] up;
    always @(posedge clock or negedge reset_n)
        if (!reset_n) up <= 2'h0;
        else up <= {up[0], 1'b1};
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // enable is stored, then the pin mode is registered: two edges of latency
    property p_gnd; up[1] && !$past(analog_mux_enable, 2) |->
        pin_mode == `ASEL_PIN_GROUND && pulldown_on && !buffer_oe; endproperty
    a_gnd: assert property (p_gnd) else $error("pin not grounded");
    property p_one; $onehot0(route_onehot) && !route_onehot[0]; endproperty
    a_one: assert property (p_one) else $error("bad route");
    property p_oe; buffer_oe |-> pin_mode == `ASEL_PIN_DRIVE && route_onehot != 25'h0; endproperty
    a_oe: assert property (p_oe) else $error("drive without route");
    property p_rsv; reserved_code |-> pin_mode == `ASEL_PIN_HIZ && route_onehot == 25'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved code routed");
    property p_sup; |route_onehot[3:1] |-> divider_code == (route_onehot[1] ? `ASEL_DIV_4 :
        route_onehot[2] ? `ASEL_DIV_3P5 : `ASEL_DIV_3); endproperty
    a_sup: assert property (p_sup) else $error("supply ratio wrong");
    property p_bck; |route_onehot[9:4] |-> divider_code ==
        ((|($past(buck_at_1p8) & route_onehot[9:4])) ? `ASEL_DIV_1P25 : `ASEL_DIV_1);
    endproperty
    a_bck: assert property (p_bck) else $error("buck ratio wrong");
    property p_lin; |route_onehot[14:10] |->
        divider_code == (route_onehot[10] ? `ASEL_DIV_2P86 : `ASEL_DIV_3P33); endproperty
    a_lin: assert property (p_lin) else $error("regulator ratio wrong");
    property p_tmp; |route_onehot[24:15] |-> divider_code == `ASEL_DIV_1; endproperty
    a_tmp: assert property (p_tmp) else $error("sensor ratio wrong");
    property p_set; up[1] && $rose(buffer_oe) |-> !settled; endproperty
    a_set: assert property (p_set) else $error("settled too early");
endmodule // asel_chk
`default_nettype wire

// file: tb.sv
// testbench for the selector control
`timescale 1ns/100ps
`default_nettype none
`include "asel_regs.vh"
module tb;
    logic clock = 1'b0, reset_n = 1'b0, analog_mux_enable = 1'b0, select_write = 1'b0;
    logic system_on = 1'b1, pulldown_on, buffer_oe, reserved_code, settled;
    logic [4:0] channel_select_field = 5'h00;
    logic [5:0] buck_at_1p8 = 6'h15;
    logic [1:0] pin_mode;
    logic [2:0] divider_code;
    logic [24:0] route_onehot;
    logic [7:0] reads;
    int fail_count = 0, checks = 0;
    asel_top #(.SETTLE_CYCLES(8)) dut (.clock, .reset_n, .analog_mux_enable, .select_write,
        .channel_select_field, .system_on, .buck_at_1p8, .pin_mode, .pulldown_on,
        .buffer_oe, .route_onehot, .divider_code, .reserved_code, .settled);
    asel_sampler u_smp (.clock, .reset_n, .buffer_oe, .settled, .reads);
    initial forever #2 clock = ~clock;
    task chk(input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task put(input logic [4:0] c);
        @(posedge clock);
        channel_select_field <= c;
        select_write <= 1'b1;
        @(posedge clock);
        select_write <= 1'b0;
        @(posedge clock);
        #1;
    endtask
    task lvl(input logic en, so);
        @(posedge clock);
        analog_mux_enable <= en;
        system_on <= so;
        repeat (3) @(posedge clock);
        #1;
    endtask
    function automatic logic [2:0] dv(int c, logic [5:0] b);
        dv = c == 0 ? `ASEL_DIV_NONE : c == 1 ? `ASEL_DIV_4 : c == 2 ? `ASEL_DIV_3P5 :
            c == 3 ? `ASEL_DIV_3 : c < 10 ? (b[c-4] ? `ASEL_DIV_1P25 : `ASEL_DIV_1) :
            c == 10 ? `ASEL_DIV_2P86 : c < 15 ? `ASEL_DIV_3P33 : c < 25 ? `ASEL_DIV_1 :
            `ASEL_DIV_NONE;
    endfunction
    task t_gnd;
        lvl(1'b0, 1'b1);
        put(5'h01);
        chk(pin_mode, `ASEL_PIN_GROUND);
        chk(pulldown_on, 1'b1);
        chk(route_onehot, 32'h0);
        lvl(1'b1, 1'b1);
        chk(route_onehot, 32'h2);
        chk(buffer_oe, 1'b1);
        chk(pulldown_on, 1'b0);
        $display("test gnd done");
    endtask
    task t_codes(input logic [5:0] b);
        @(posedge clock);
        buck_at_1p8 <= b;
        for (int c = 0; c < 32; c++) begin
            put(c[4:0]);
            chk(route_onehot, c > 0 && c < 25 ? 32'h1 << c : 32'h0);
            chk(pin_mode, c > 0 && c < 25 ? `ASEL_PIN_DRIVE : `ASEL_PIN_HIZ);
            chk(reserved_code, c > 24);
            chk(divider_code, dv(c, b));
        end
        $display("test codes done");
    endtask
    task t_settle;
        put(5'h0f);
        chk(settled, 1'b0);
        repeat (10) @(posedge clock);
        #1;
        chk(settled, 1'b1);
        chk(reads != 8'h00, 1'b1);
        $display("test settle done");
    endtask
    task t_off;
        lvl(1'b1, 1'b0);
        chk(pin_mode, `ASEL_PIN_HIZ);
        chk(buffer_oe, 1'b0);
        lvl(1'b0, 1'b1);
        chk(pin_mode, `ASEL_PIN_GROUND);
        chk(pulldown_on, 1'b1);
        chk(route_onehot, 32'h0);
        $display("test off done");
    endtask
    task complete_run;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        t_gnd;
        t_codes(6'h15);
        t_codes(6'h2a);
        t_settle;
        t_off;
        complete_run;
    end
    initial begin
        #20000;
        fail_count++;
        complete_run;
    end
endmodule // tb
bind asel_top asel_chk u_chk (.clock, .reset_n, .analog_mux_enable, .buck_at_1p8,
    .pulldown_on, .buffer_oe,
    .reserved_code, .settled, .pin_mode, .divider_code, .route_onehot);
`default_nettype wire
